// file: logic/eegc_pkg.sv
// package for the embedded event and gpio control register bank
// assumes a 32-bit axi4-lite bus with 12-bit byte addresses
package eegc_pkg;
   // ************************************************
   // clock and timing
   // ************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int RESP_MAX_NS = 150000;
   // longest time, rounded down to whole cycles
   localparam int RESP_MAX_CYC = RESP_MAX_NS / CLK_PERIOD_NS;

   // ************************************************
   // bus geometry
   // ************************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ************************************************
   // register indices, byte address is four times the index
   // ************************************************
   localparam logic [7:0] IDX_CTL_RUN_EN = 8'hb0;
   localparam logic [7:0] IDX_CTL_WAKE_EN = 8'hb1;
   localparam logic [7:0] IDX_BAT_RUN_EN = 8'hb2;
   localparam logic [7:0] IDX_BAT_WAKE_EN = 8'hb3;
   localparam logic [7:0] IDX_A_DIR = 8'hb4;
   localparam logic [7:0] IDX_A_VAL = 8'hb5;
   localparam logic [7:0] IDX_A_RUN_EN = 8'hb6;
   localparam logic [7:0] IDX_A_EDGE = 8'hb7;
   localparam logic [7:0] IDX_A_WAKE_EN = 8'hb8;
   localparam logic [7:0] IDX_B_DIR = 8'hb9;
   localparam logic [7:0] IDX_B_VAL = 8'hba;
   localparam logic [7:0] IDX_B_RUN_EN = 8'hbb;
   localparam logic [7:0] IDX_B_EDGE = 8'hbc;
   localparam logic [7:0] IDX_B_WAKE_EN = 8'hbd;
   localparam logic [7:0] IDX_C_VAL = 8'hbe;
   localparam logic [7:0] IDX_C_RUN_EN = 8'hbf;
   localparam logic [7:0] IDX_EVT_STATUS = 8'hc8;
   localparam logic [7:0] IDX_EVT_MASK = 8'hc9;
   localparam logic [7:0] IDX_BURST_CLR = 8'hca;

   // ************************************************
   // reset values and field layout
   // ************************************************
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_B_DIR = 8'h80;
   localparam logic [6:0] B_PIN_MASK = 7'h7f;
   localparam logic [1:0] C_PIN_MASK = 2'h3;
   // controller enable bits used: trip point 2, bus, alert, adapter
   localparam logic [7:0] CTL_EN_MASK = 8'he1;
   localparam logic [7:0] BURST_CLR_VALUE = 8'h00;

   // sticky event layout, also the mask layout
   typedef struct packed {
      logic [1:0] resv;
      logic [7:0] bat;
      logic [3:0] ctl;  // trip2, bus, alert, adapter
      logic [1:0] pin_c;
      logic [6:0] pin_b;
      logic [7:0] pin_a;
   } eegc_evt_t;

   // pin outputs of one gpio group pair
   typedef struct packed {
      logic [6:0] b_out;
      logic [6:0] b_oe;
      logic [7:0] a_out;
      logic [7:0] a_oe;
   } eegc_pins_t;
endpackage : eegc_pkg

// file: logic/eegc_top.sv
// control register bank for controller, battery and gpio events
// assumes pins and event inputs synchronous to aclk, axi4-lite master
// How it works
// - registers flagged for retention keep their contents while deep_sleep is high.
// - a read-only-with-write register reads back host data until refresh or a pin change.
// - every register access is answered well within 150 microseconds.
// - each group a or b edge select bit picks falling edge at 0 and rising edge at 1.
// - controller enables hold trip point 2 and bus event bits, 1 enables and 0 disables.
// - controller enables also hold bus alert and adapter bits, 1 enables and 0 disables.
// - battery enables hold trip, depleted, low and caution bits, all reset to zero.
// - battery enables also hold fault, learning, charge change and presence bits.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module eegc_top
   import eegc_pkg::*;
#(
   parameter int RESP_LIMIT_CYC = RESP_MAX_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // power state
   input wire logic deep_sleep,
   input wire logic state_clear,
   // event sources, active high levels
   input wire logic [3:0] ctl_evt_in,
   input wire logic [7:0] bat_evt_in,
   // gpio pins
   input wire logic [7:0] pin_a_in,
   input wire logic [6:0] pin_b_in,
   input wire logic [1:0] pin_c_in,
   output eegc_pins_t pins,
   // notifications
   output logic irq,
   output logic wake
);

   // ************************************************
   // helpers
   // ************************************************
   // register index of an aligned byte address, 8'h00 if misaligned
   function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
      if (a[1:0] != 2'h0) begin
         return 8'h00;
      end
      return a[9:2];
   endfunction : reg_index

   // edge picked by the select bit: 0 falling, 1 rising
   function automatic logic [7:0] edge_hit(input logic [7:0] now, input logic [7:0] was,
                                           input logic [7:0] sel);
      return (sel & now & ~was) | (~sel & ~now & was);
   endfunction : edge_hit

   // ************************************************
   // registers
   // ************************************************
   logic [7:0] ctl_run_en_r, ctl_wake_en_r, bat_run_en_r, bat_wake_en_r;
   logic [7:0] a_dir_r, a_val_r, a_run_en_r, a_edge_r, a_wake_en_r;
   logic [7:0] b_dir_r, b_val_r, b_run_en_r, b_edge_r, b_wake_en_r;
   logic [7:0] c_run_en_r;
   logic [7:0] a_seen_r, b_seen_r, c_seen_r;
   eegc_evt_t status_r, mask_r, status_nxt, evt_set;
   logic burst_r;
   logic [31:0] w32_r;
   logic [7:0] pin_a_q, pin_b_q, pin_c_q;
   logic [3:0] ctl_q;
   logic [7:0] bat_q;
   logic [31:0] refresh_cnt_r;
   logic refresh;

   // ************************************************
   // write channel
   // ************************************************
   logic aw_held_r, w_held_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [7:0] wdata_r;
   logic wlane_r;
   logic do_write;
   logic [7:0] widx;
   logic wr_hit;

   assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
   assign widx = reg_index(awaddr_r);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         awaddr_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r <= 1'b0;
         wdata_r <= 8'h00;
         wlane_r <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r <= 1'b1;
         wdata_r <= s_axi_wdata[7:0];
         wlane_r <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_held_r <= 1'b0;
      end
   end

   // ready only while the holding slot is free
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !(aw_held_r || (s_axi_awvalid && s_axi_awready)) || do_write;
         s_axi_wready <= !(w_held_r || (s_axi_wvalid && s_axi_wready)) || do_write;
      end
   end

   always_comb begin
      wr_hit = 1'b1;
      if (awaddr_r[ADDR_W-1:10] != '0 || awaddr_r[1:0] != 2'h0) begin
         wr_hit = 1'b0;
      end else if (widx >= IDX_CTL_RUN_EN && widx <= IDX_C_RUN_EN) begin
         wr_hit = 1'b1;
      end else if (widx >= IDX_EVT_STATUS && widx <= IDX_BURST_CLR) begin
         wr_hit = 1'b1;
      end else begin
         wr_hit = 1'b0;
      end
   end

   // answer one cycle after both halves are held, far inside the limit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   logic wr;
   assign wr = do_write && wr_hit && wlane_r;

   // ************************************************
   // enable and edge registers
   // ************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_run_en_r <= RST_ZERO;
         ctl_wake_en_r <= RST_ZERO;
         bat_run_en_r <= RST_ZERO;
         bat_wake_en_r <= RST_ZERO;
         a_run_en_r <= RST_ZERO;
         a_edge_r <= RST_ZERO;
         a_wake_en_r <= RST_ZERO;
         b_run_en_r <= RST_ZERO;
         b_edge_r <= RST_ZERO;
         b_wake_en_r <= RST_ZERO;
         c_run_en_r <= RST_ZERO;
      end else if (wr) begin
         if (widx == IDX_CTL_RUN_EN) begin
            ctl_run_en_r <= wdata_r & CTL_EN_MASK;
         end else if (widx == IDX_CTL_WAKE_EN) begin
            ctl_wake_en_r <= wdata_r & CTL_EN_MASK;
         end else if (widx == IDX_BAT_RUN_EN) begin
            bat_run_en_r <= wdata_r;
         end else if (widx == IDX_BAT_WAKE_EN) begin
            bat_wake_en_r <= wdata_r;
         end else if (widx == IDX_A_RUN_EN) begin
            a_run_en_r <= wdata_r;
         end else if (widx == IDX_A_EDGE) begin
            a_edge_r <= wdata_r;
         end else if (widx == IDX_A_WAKE_EN) begin
            a_wake_en_r <= wdata_r;
         end else if (widx == IDX_B_RUN_EN) begin
            b_run_en_r <= {1'b0, wdata_r[6:0] & B_PIN_MASK};
         end else if (widx == IDX_B_EDGE) begin
            b_edge_r <= {1'b0, wdata_r[6:0] & B_PIN_MASK};
         end else if (widx == IDX_B_WAKE_EN) begin
            b_wake_en_r <= {1'b0, wdata_r[6:0] & B_PIN_MASK};
         end else if (widx == IDX_C_RUN_EN) begin
            c_run_en_r <= {6'h00, wdata_r[1:0] & C_PIN_MASK};
         end
      end
   end

   // ************************************************
   // retained direction and pin value registers
   // ************************************************
   // a state clear outside deep sleep reverts them; in deep sleep they hold
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a_dir_r <= RST_ZERO;
         b_dir_r <= RST_B_DIR;
         a_val_r <= RST_ZERO;
         b_val_r <= RST_ZERO;
      end else if (state_clear && !deep_sleep) begin
         a_dir_r <= RST_ZERO;
         b_dir_r <= RST_B_DIR;
         a_val_r <= RST_ZERO;
         b_val_r <= RST_ZERO;
      end else if (wr) begin
         if (widx == IDX_A_DIR) begin
            a_dir_r <= wdata_r;
         end else if (widx == IDX_B_DIR) begin
            b_dir_r <= wdata_r;
         end else if (widx == IDX_A_VAL) begin
            a_val_r <= wdata_r;
         end else if (widx == IDX_B_VAL) begin
            b_val_r <= {1'b0, wdata_r[6:0]};
         end
      end
   end

   // pins driven only where the direction bit is 1
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pins <= '0;
      end else begin
         pins.a_out <= a_val_r;
         pins.a_oe <= a_dir_r;
         pins.b_out <= b_val_r[6:0];
         pins.b_oe <= b_dir_r[6:0];
      end
   end

   // ************************************************
   // readback of input pins
   // ************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         refresh_cnt_r <= 32'h0;
      end else if (refresh) begin
         refresh_cnt_r <= 32'h0;
      end else begin
         refresh_cnt_r <= refresh_cnt_r + 32'h1;
      end
   end
   assign refresh = (refresh_cnt_r >= 32'(RESP_LIMIT_CYC - 1));

   // written data shadows an input pin until the pin moves or a refresh
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a_seen_r <= RST_ZERO;
         b_seen_r <= RST_ZERO;
         c_seen_r <= RST_ZERO;
      end else begin
         if (wr && widx == IDX_A_VAL) begin
            a_seen_r <= wdata_r;
         end else if (refresh || pin_a_in != pin_a_q) begin
            a_seen_r <= pin_a_in;
         end
         if (wr && widx == IDX_B_VAL) begin
            b_seen_r <= {1'b0, wdata_r[6:0]};
         end else if (refresh || {1'b0, pin_b_in} != pin_b_q) begin
            b_seen_r <= {1'b0, pin_b_in};
         end
         if (wr && widx == IDX_C_VAL) begin
            c_seen_r <= {6'h00, wdata_r[1:0]};
         end else if (refresh || {6'h00, pin_c_in} != pin_c_q) begin
            c_seen_r <= {6'h00, pin_c_in};
         end
      end
   end

   // ************************************************
   // event detection
   // ************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_a_q <= RST_ZERO;
         pin_b_q <= RST_ZERO;
         pin_c_q <= RST_ZERO;
         ctl_q <= 4'h0;
         bat_q <= RST_ZERO;
      end else begin
         pin_a_q <= pin_a_in;
         pin_b_q <= {1'b0, pin_b_in};
         pin_c_q <= {6'h00, pin_c_in};
         ctl_q <= ctl_evt_in;
         bat_q <= bat_evt_in;
      end
   end

   logic [3:0] ctl_en;
   logic [7:0] b_hit;
   assign ctl_en = {ctl_run_en_r[7:5], ctl_run_en_r[0]} | {ctl_wake_en_r[7:5], ctl_wake_en_r[0]};
   assign b_hit = edge_hit({1'b0, pin_b_in}, pin_b_q, b_edge_r);

   always_comb begin
      evt_set = '0;
      evt_set.pin_a = edge_hit(pin_a_in, pin_a_q, a_edge_r) & (a_run_en_r | a_wake_en_r);
      evt_set.pin_b = b_hit[6:0] & (b_run_en_r[6:0] | b_wake_en_r[6:0]);
      // group c has no edge select register; rising edge only here
      evt_set.pin_c = pin_c_in & ~pin_c_q[1:0] & c_run_en_r[1:0];
      evt_set.ctl = ctl_evt_in & ~ctl_q & ctl_en;
      evt_set.bat = bat_evt_in & ~bat_q & (bat_run_en_r | bat_wake_en_r);
   end

   // ************************************************
   // sticky status, mask, burst flag
   // ************************************************
   always_comb begin
      status_nxt = status_r;
      if (wr && widx == IDX_EVT_STATUS) begin
         status_nxt = status_r & ~eegc_evt_t'(w32_r[30:0]);
      end
      // set beats a same-cycle clear
      status_nxt = status_nxt | evt_set;
      status_nxt.resv = 2'h0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w32_r <= 32'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w32_r <= s_axi_wdata;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= '0;
      end else begin
         status_r <= status_nxt;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_r <= '0;
      end else if (wr && widx == IDX_EVT_MASK) begin
         mask_r <= eegc_evt_t'(w32_r[30:0] & 31'h1fffffff);
      end
   end

   // status writes raise the burst flag, a zero write to the clear drops it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         burst_r <= 1'b0;
      end else if (wr && widx == IDX_EVT_STATUS) begin
         burst_r <= 1'b1;
      end else if (wr && widx == IDX_BURST_CLR && wdata_r == BURST_CLR_VALUE) begin
         burst_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
         wake <= 1'b0;
      end else begin
         irq <= |(status_r & mask_r);
         wake <= |(status_r.pin_a & a_wake_en_r) | |(status_r.pin_b & b_wake_en_r[6:0]) |
                 |(status_r.ctl & {ctl_wake_en_r[7:5], ctl_wake_en_r[0]}) |
                 |(status_r.bat & bat_wake_en_r);
      end
   end

   // ************************************************
   // read channel
   // ************************************************
   logic [7:0] ridx;
   logic [DATA_W-1:0] rd_val;
   logic rd_hit;
   assign ridx = reg_index(s_axi_araddr);

   always_comb begin
      rd_val = 32'h0;
      rd_hit = 1'b1;
      if (s_axi_araddr[ADDR_W-1:10] != '0 || s_axi_araddr[1:0] != 2'h0) begin
         rd_hit = 1'b0;
      end else if (ridx == IDX_CTL_RUN_EN) begin
         rd_val = {24'h0, ctl_run_en_r};
      end else if (ridx == IDX_CTL_WAKE_EN) begin
         rd_val = {24'h0, ctl_wake_en_r};
      end else if (ridx == IDX_BAT_RUN_EN) begin
         rd_val = {24'h0, bat_run_en_r};
      end else if (ridx == IDX_BAT_WAKE_EN) begin
         rd_val = {24'h0, bat_wake_en_r};
      end else if (ridx == IDX_A_DIR) begin
         rd_val = {24'h0, a_dir_r};
      end else if (ridx == IDX_A_VAL) begin
         rd_val = {24'h0, (a_val_r & a_dir_r) | (a_seen_r & ~a_dir_r)};
      end else if (ridx == IDX_A_RUN_EN) begin
         rd_val = {24'h0, a_run_en_r};
      end else if (ridx == IDX_A_EDGE) begin
         rd_val = {24'h0, a_edge_r};
      end else if (ridx == IDX_A_WAKE_EN) begin
         rd_val = {24'h0, a_wake_en_r};
      end else if (ridx == IDX_B_DIR) begin
         rd_val = {24'h0, b_dir_r};
      end else if (ridx == IDX_B_VAL) begin
         rd_val = {24'h0, 1'b0, (b_val_r[6:0] & b_dir_r[6:0]) | (b_seen_r[6:0] & ~b_dir_r[6:0])};
      end else if (ridx == IDX_B_RUN_EN) begin
         rd_val = {24'h0, b_run_en_r};
      end else if (ridx == IDX_B_EDGE) begin
         rd_val = {24'h0, b_edge_r};
      end else if (ridx == IDX_B_WAKE_EN) begin
         rd_val = {24'h0, b_wake_en_r};
      end else if (ridx == IDX_C_VAL) begin
         rd_val = {24'h0, c_seen_r};
      end else if (ridx == IDX_C_RUN_EN) begin
         rd_val = {24'h0, c_run_en_r};
      end else if (ridx == IDX_EVT_STATUS) begin
         rd_val = 32'(status_r);
      end else if (ridx == IDX_EVT_MASK) begin
         rd_val = 32'(mask_r);
      end else if (ridx == IDX_BURST_CLR) begin
         rd_val = {31'h0, burst_r};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // one read in flight; data one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule : eegc_top
`default_nettype wire

// file: bench/eegc_props.sv
// assertions on the ports of the event and gpio register bank
// assumes it is bound to eegc_top and clocked by its aclk
`timescale 1ns/1ps
`default_nettype none
module eegc_props
   import eegc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // power state and outputs
   input wire logic deep_sleep,
   input wire logic state_clear,
   input wire eegc_pins_t pins,
   input wire logic irq,
   input wire logic wake
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ******
   // sequences
   // ******
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // a write reaches the pins one cycle after its bvalid
   sequence s_quiet;
      deep_sleep && state_clear && !s_axi_bvalid;
   endsequence
   a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while busy");
   a_arready_back: assert property (s_axi_rvalid && s_axi_rready |=> s_axi_arready)
      else $error("read not reopened");
   a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !wake
      && pins.a_oe == 8'h00 && pins.b_oe == 7'h00)
      else $error("outputs active after reset");
   a_sleep_keeps: assert property (s_quiet ##1 !s_axi_bvalid ##1 s_quiet
      |-> $stable(pins.a_oe) && $stable(pins.b_oe))
      else $error("direction lost in deep sleep");
   a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY
      || s_axi_bresp == RESP_SLVERR)
      else $error("bad write response code");
endmodule : eegc_props
bind eegc_top eegc_props u_eegc_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .deep_sleep, .state_clear,
   .pins, .irq, .wake);
`default_nettype wire

// file: bench/eegc_top_tb.sv
// self-checking bench for the event and gpio register bank
// assumes eegc_top with a short refresh period of 20 cycles
`timescale 1ns/1ps
`default_nettype none
module eegc_top_tb;
   import eegc_pkg::*;
   logic aclk, aresetn, deep_sleep, state_clear, irq, wake;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, ctl_evt_in;
   logic [1:0] s_axi_bresp, s_axi_rresp, pin_c_in, rs;
   logic [7:0] bat_evt_in, pin_a_in;
   logic [6:0] pin_b_in;
   eegc_pins_t pins;
   int bad_count, num_checks;
   eegc_top #(.RESP_LIMIT_CYC(20)) u_eegc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .deep_sleep,
      .state_clear, .ctl_evt_in, .bat_evt_in, .pin_a_in, .pin_b_in, .pin_c_in, .pins, .irq,
      .wake);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // ******
   // bus and compare tasks
   // ******
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= {2'h0, idx, 2'h0};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      rs = s_axi_bresp;
   endtask : wr
   task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
      @(posedge aclk);
      s_axi_araddr <= {2'h0, idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rs = s_axi_rresp;
      chk(s_axi_rdata, exp);
   endtask : rchk
   // ******
   // scenarios
   // ******
   task automatic t_regs;
      logic [7:0] idx [11] = '{IDX_CTL_RUN_EN, IDX_CTL_WAKE_EN, IDX_BAT_RUN_EN, IDX_BAT_WAKE_EN,
         IDX_A_RUN_EN, IDX_A_EDGE, IDX_A_WAKE_EN, IDX_B_RUN_EN, IDX_B_EDGE, IDX_B_WAKE_EN,
         IDX_C_RUN_EN};
      logic [7:0] msk [11] = '{CTL_EN_MASK, CTL_EN_MASK, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
         8'h7f, 8'h7f, 8'h7f, 8'h03};
      rchk(IDX_A_DIR, 32'h0);
      rchk(IDX_B_DIR, {24'h0, RST_B_DIR});
      for (int i = 0; i < 11; i++) begin
         rchk(idx[i], 32'h0);
         wr(idx[i], 32'hff);
         rchk(idx[i], {24'h0, msk[i]});
         wr(idx[i], 32'h0);
      end
      wr(8'hc0, 32'hff);
      chk(rs, RESP_SLVERR);
      rchk(8'hc0, 32'h0);
      chk(rs, RESP_SLVERR);
   endtask : t_regs
   task automatic t_dir;
      wr(IDX_A_DIR, 32'ha5);
      wr(IDX_A_VAL, 32'h3c);
      repeat (2) @(posedge aclk);
      chk(pins.a_oe, 8'ha5);
      chk(pins.a_out & pins.a_oe, 8'h24);
      repeat (25) @(posedge aclk);
      rchk(IDX_A_VAL, 32'h24);
      pin_a_in <= 8'h42;
      repeat (3) @(posedge aclk);
      rchk(IDX_A_VAL, 32'h66);
      deep_sleep <= 1'b1;
      state_clear <= 1'b1;
      repeat (6) @(posedge aclk);
      chk(pins.a_oe, 8'ha5);
      rchk(IDX_A_DIR, 32'ha5);
      deep_sleep <= 1'b0;
      repeat (3) @(posedge aclk);
      state_clear <= 1'b0;
      rchk(IDX_A_DIR, 32'h0);
      chk(pins.b_oe, 32'h0);
   endtask : t_dir
   task automatic t_edge;
      wr(IDX_EVT_MASK, 32'hffffffff);
      wr(IDX_EVT_STATUS, 32'hffffffff);
      wr(IDX_BURST_CLR, {24'h0, BURST_CLR_VALUE});
      wr(IDX_A_RUN_EN, 32'h01);
      pin_a_in <= 8'h43;
      repeat (3) @(posedge aclk);
      chk(irq, 1'b0);
      pin_a_in <= 8'h02;
      repeat (3) @(posedge aclk);
      chk(irq, 1'b1);
      rchk(IDX_EVT_STATUS, 32'h1);
      wr(IDX_EVT_STATUS, 32'h1);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      rchk(IDX_BURST_CLR, 32'h1);
      wr(IDX_BURST_CLR, {24'h0, BURST_CLR_VALUE});
      rchk(IDX_BURST_CLR, 32'h0);
      wr(IDX_A_RUN_EN, 32'h0);
      wr(IDX_A_EDGE, 32'h1);
      wr(IDX_A_WAKE_EN, 32'h1);
      pin_a_in <= 8'h03;
      repeat (3) @(posedge aclk);
      chk(wake, 1'b1);
      chk(irq, 1'b1);
      wr(IDX_EVT_MASK, 32'h0);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      wr(IDX_EVT_STATUS, 32'hffffffff);
      wr(IDX_BURST_CLR, {24'h0, BURST_CLR_VALUE});
      repeat (2) @(posedge aclk);
      chk(wake, 1'b0);
      wr(IDX_CTL_WAKE_EN, 32'h80);
      wr(IDX_BAT_RUN_EN, 32'h01);
      ctl_evt_in <= 4'h9;
      bat_evt_in <= 8'h03;
      repeat (3) @(posedge aclk);
      rchk(IDX_EVT_STATUS, 32'h300000);
      chk(wake, 1'b1);
   endtask : t_edge
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   initial begin
      {aresetn, deep_sleep, state_clear, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awprot, s_axi_arprot, ctl_evt_in, bat_evt_in} = '0;
      {pin_a_in, pin_b_in, pin_c_in} = '0;
      s_axi_wstrb = 4'hf;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_dir;
      t_edge;
      finish_test;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      finish_test;
   end
endmodule : eegc_top_tb
`default_nettype wire
